// file: rtl/osc_timer_params.svh
// Overview of operation
// R1 - Two count bytes; split selects 16 or 8+8
// R2 - Clocks: core, core/12, external/8, slow/8
// R3 - Slow sources synchronised except during suspend; both are always synchronised here
// R4 - Counts in suspend; overflow wakes device
// R5 - Busy flag up to three ticks after wake
// R6 - Slow oscillator divider must be one
// R7 - 16-bit wrap reloads, sets high flag
// R8 - Timer enable requests interrupt on overflow
// R9 - Low enable adds low-byte wrap interrupts
// R10 - Split: each byte reloads from own byte
// R11 - Split: run gates high byte only
// R12 - Per-byte select: core or external field
// R13 - Split: each byte wrap sets own flag
// R14 - Split interrupts: high, or either if enabled
// R15 - Flags cleared only by software
// R16 - Capture copies count to reload, sets flag
// R17 - Capture clock from low select and field
// R18 - Capture clock should be much faster
// R19 - Software may preload count before suspend
// R20 - Control register 0x91, reset zero, layout
// R21 - Reserved clock code stops that byte
`ifndef OSC_TIMER_PARAMS_SVH
`define OSC_TIMER_PARAMS_SVH

// ==========================================================
// Control register
`define CTRL_SFR_ADDR     8'h91
`define CTRL_RESET        8'h00

// ==========================================================
// External clock field codes
`define XCLK_CORE_DIV12   2'h0
`define XCLK_EXT_DIV8     2'h1
`define XCLK_RESERVED     2'h2
`define XCLK_SLOW_OSC     2'h3

// ==========================================================
// Dividers and timing counts
`define CORE_DIV_LAST     4'hB
`define SLOW_DIV_LAST     3'h7
`define BUSY_TICKS        2'h3
`define BYTE_ALL_ONES     8'hFF
`define BYTE_ZERO         8'h00

`endif

// file: rtl/osc_timer_pkg.sv
`default_nettype none

// ==========================================================
// Types shared by the timer files
package osc_timer_pkg;

    // Control register image, bit 7 down to bit 0
    typedef struct packed {
        logic       high_overflow_flag;
        logic       low_overflow_flag;
        logic       low_byte_irq_enable;
        logic       osc_capture_enable;
        logic       split_mode_select;
        logic       run_control;
        logic [1:0] ext_clock_field;
    } timer_control_t;

    // One-cycle software write strobes
    typedef struct packed {
        logic control;
        logic reload_low;
        logic reload_high;
        logic count_low;
        logic count_high;
    } write_strobe_t;

    // Per-byte clock selects from the clock select register
    typedef struct packed {
        logic high_byte_clock_select;
        logic low_byte_clock_select;
    } clock_select_t;

    // Suspend and resynchronisation tracking
    typedef enum logic [1:0] {
        ST_AWAKE,
        ST_SUSPENDED,
        ST_BUSY
    } wake_state_t;

endpackage

`default_nettype wire

// file: rtl/edge_div8.sv
`timescale 1ns/1ps
`default_nettype none
`include "osc_timer_params.svh"

// ==========================================================
// Pin synchroniser, falling-edge detect and divide by eight
module edge_div8 (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Asynchronous source pin
    input  wire logic src,
    // Pulses on the core clock
    output logic      fall_q,
    output logic      tick_q
);

    logic       sync1_q;
    logic       sync2_q;
    logic       prev_q;
    logic [2:0] div_q;
    wire        rise_w = sync2_q & ~prev_q;
    wire        fall_w = prev_q & ~sync2_q;

    // Two flops before anything looks at the pin
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
            div_q   <= 3'h0;
            fall_q  <= 1'b0;
            tick_q  <= 1'b0;
        end
        else
        begin
            sync1_q <= src;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            fall_q  <= fall_w;
            tick_q  <= rise_w & (div_q == `SLOW_DIV_LAST);
            if (rise_w)
                div_q <= div_q + 3'h1;
        end
    end

endmodule // edge_div8

`default_nettype wire

// file: rtl/osc_capture_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "osc_timer_params.svh"

// ==========================================================
// Auto-reload timer with slow oscillator capture
module osc_capture_timer
    import osc_timer_pkg::*;
(
    // Clock and reset
    input  wire logic          CLK,
    input  wire logic          RSTN,
    // Software writes
    input  wire write_strobe_t WR_STROBE,
    input  wire logic [7:0]    WR_DATA,
    // Configuration bits from other registers
    input  wire clock_select_t CLOCK_SELECT,
    input  wire logic          TIMER_IRQ_ENABLE,
    input  wire logic          SLOW_DIV_IS_ONE,
    input  wire logic          SUSPEND,
    // Oscillator pins
    input  wire logic          EXT_OSC_CLK,
    input  wire logic          SLOW_OSC_CLK,
    // Register images
    output timer_control_t     TIMER_CONTROL,
    output logic [7:0]         COUNT_LOW,
    output logic [7:0]         COUNT_HIGH,
    output logic [7:0]         RELOAD_LOW,
    output logic [7:0]         RELOAD_HIGH,
    // Events toward the core
    output logic               TIMER_IRQ,
    output logic               WAKE_REQ,
    output logic               SYNC_BUSY_FLAG
);

    // ==========================================================
    // Tick selection
    function automatic logic pick_tick(
        input logic       use_core,
        input logic [1:0] field,
        input logic       t12,
        input logic       te8,
        input logic       ts8
    );
        logic t;
        t = 1'b0;
        if (use_core)
            t = 1'b1;
        else
        begin
            case (field)
                `XCLK_CORE_DIV12: t = t12;
                `XCLK_EXT_DIV8:   t = te8;
                `XCLK_SLOW_OSC:   t = ts8;
                default:          t = 1'b0;
            endcase
        end
        return t;
    endfunction

    timer_control_t ctrl_q;
    timer_control_t ctrl_d;
    logic [3:0]     div12_q;
    logic           tick12_q;
    logic           ext_tick;
    logic           slow_tick;
    logic           slow_fall;
    logic [7:0]     cnt_lo_d;
    logic [7:0]     cnt_hi_d;
    logic [7:0]     rld_lo_d;
    logic [7:0]     rld_hi_d;
    wake_state_t    state_q;
    wake_state_t    state_d;
    logic           susp_prev_q;
    logic [1:0]     busy_cnt_q;
    logic [1:0]     busy_cnt_d;
    logic           irq_d;

    // Both slow sources pass the synchroniser; a true suspend
    // path would bypass it, which this one-clock model cannot.
    edge_div8 ext_sync (
        .clk    (CLK),
        .rstn   (RSTN),
        .src    (EXT_OSC_CLK),
        .fall_q (),
        .tick_q (ext_tick)
    );                                                  // see R3

    edge_div8 slow_sync (
        .clk    (CLK),
        .rstn   (RSTN),
        .src    (SLOW_OSC_CLK),
        .fall_q (slow_fall),
        .tick_q (slow_tick)
    );                                                  // see R3

    // Core clock divided by twelve
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            div12_q  <= 4'h0;
            tick12_q <= 1'b0;
        end
        else
        begin
            div12_q  <= (div12_q == `CORE_DIV_LAST) ? 4'h0 : div12_q + 4'h1;   // see R2
            tick12_q <= (div12_q == `CORE_DIV_LAST);
        end
    end

    // ==========================================================
    // Count steps and wraps
    // Slow source counts only with divider at one
    wire slow_ok   = slow_tick & SLOW_DIV_IS_ONE;          // see R6
    wire split     = ctrl_q.split_mode_select;
    wire run       = ctrl_q.run_control;
    wire tick_lo   = pick_tick(CLOCK_SELECT.low_byte_clock_select, ctrl_q.ext_clock_field,
                               tick12_q, ext_tick, slow_ok);   // see R12 R17 R21
    wire tick_hi   = pick_tick(CLOCK_SELECT.high_byte_clock_select, ctrl_q.ext_clock_field,
                               tick12_q, ext_tick, slow_ok);   // see R12 R21
    wire tick16    = tick_lo & run & ~split;               // see R1
    wire lo_step   = split ? tick_lo : tick16;             // see R11
    wire hi_step   = split ? (tick_hi & run) : (tick16 & (COUNT_LOW == `BYTE_ALL_ONES));   // see R11
    wire lo_wrap   = lo_step & (COUNT_LOW == `BYTE_ALL_ONES);
    wire hi_wrap   = hi_step & (COUNT_HIGH == `BYTE_ALL_ONES);
    wire lo_reload = lo_wrap & (split | hi_wrap);          // see R7 R10
    wire cap_ev    = ctrl_q.osc_capture_enable & slow_fall;    // see R16
    wire hi_set    = hi_wrap | cap_ev;                     // see R7 R13 R16
    wire lo_set    = lo_wrap;                              // see R13
    timer_control_t wr_ctrl;
    assign wr_ctrl = timer_control_t'(WR_DATA);

    // Next count bytes; a software write beats a tick
    always_comb
    begin
        cnt_lo_d = COUNT_LOW;
        cnt_hi_d = COUNT_HIGH;
        if (WR_STROBE.count_low)
            cnt_lo_d = WR_DATA;                            // see R19
        else if (lo_reload)
            cnt_lo_d = RELOAD_LOW;                         // see R7 R10
        else if (lo_wrap)
            cnt_lo_d = `BYTE_ZERO;
        else if (lo_step)
            cnt_lo_d = COUNT_LOW + 8'h01;
        if (WR_STROBE.count_high)
            cnt_hi_d = WR_DATA;                            // see R19
        else if (hi_wrap)
            cnt_hi_d = RELOAD_HIGH;                        // see R7 R10
        else if (hi_step)
            cnt_hi_d = COUNT_HIGH + 8'h01;
    end

    // Reload bytes; capture beats a write in the same cycle
    always_comb
    begin
        rld_lo_d = RELOAD_LOW;
        rld_hi_d = RELOAD_HIGH;
        if (cap_ev)
        begin
            rld_lo_d = COUNT_LOW;                          // see R16
            rld_hi_d = COUNT_HIGH;                         // see R16
        end
        else
        begin
            if (WR_STROBE.reload_low)
                rld_lo_d = WR_DATA;
            if (WR_STROBE.reload_high)
                rld_hi_d = WR_DATA;
        end
    end

    // Control image; hardware sets win over a clearing write
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (WR_STROBE.control)
            ctrl_d = wr_ctrl;                              // see R20
        ctrl_d.high_overflow_flag = ctrl_d.high_overflow_flag | hi_set;   // see R15
        ctrl_d.low_overflow_flag  = ctrl_d.low_overflow_flag | lo_set;    // see R15
    end

    // Same request rule in both modes
    assign irq_d = TIMER_IRQ_ENABLE & (ctrl_q.high_overflow_flag
                 | (ctrl_q.low_byte_irq_enable & ctrl_q.low_overflow_flag));   // see R8 R9 R14

    // ==========================================================
    // Suspend tracking and resync busy window
    always_comb
    begin
        state_d    = state_q;
        busy_cnt_d = busy_cnt_q;
        case (state_q)
            ST_AWAKE:
            begin
                if (SUSPEND & ~susp_prev_q)
                    state_d = ST_SUSPENDED;
            end
            ST_SUSPENDED:
            begin
                if (hi_wrap)
                    state_d = ST_AWAKE;                    // see R4
                else if (!SUSPEND)
                begin
                    state_d    = ST_BUSY;                  // see R5
                    busy_cnt_d = 2'h0;
                end
            end
            ST_BUSY:
            begin
                if (SUSPEND & ~susp_prev_q)
                    state_d = ST_SUSPENDED;
                else if (tick_lo)
                begin
                    busy_cnt_d = busy_cnt_q + 2'h1;
                    if (busy_cnt_q == `BUSY_TICKS - 2'h1)
                        state_d = ST_AWAKE;                // see R5
                end
            end
            default:
                state_d = ST_AWAKE;
        endcase
    end

    // ==========================================================
    // State registers
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            ctrl_q      <= timer_control_t'(`CTRL_RESET);
            COUNT_LOW   <= 8'h00;
            COUNT_HIGH  <= 8'h00;
            RELOAD_LOW  <= 8'h00;
            RELOAD_HIGH <= 8'h00;
        end
        else
        begin
            ctrl_q      <= ctrl_d;
            COUNT_LOW   <= cnt_lo_d;
            COUNT_HIGH  <= cnt_hi_d;
            RELOAD_LOW  <= rld_lo_d;
            RELOAD_HIGH <= rld_hi_d;
        end
    end

    // Event outputs and wake state
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            state_q        <= ST_AWAKE;
            busy_cnt_q     <= 2'h0;
            susp_prev_q    <= 1'b0;
            TIMER_IRQ      <= 1'b0;
            WAKE_REQ       <= 1'b0;
            SYNC_BUSY_FLAG <= 1'b0;
            TIMER_CONTROL  <= timer_control_t'(`CTRL_RESET);
        end
        else
        begin
            state_q        <= state_d;
            busy_cnt_q     <= busy_cnt_d;
            susp_prev_q    <= SUSPEND;
            TIMER_IRQ      <= irq_d;
            WAKE_REQ       <= (state_q == ST_SUSPENDED) & hi_wrap;   // see R4
            SYNC_BUSY_FLAG <= (state_d == ST_BUSY);                  // see R5
            TIMER_CONTROL  <= ctrl_d;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    wrap_reload_a: assert property (                                  // see R7
        (hi_wrap && !split && !cap_ev && !WR_STROBE.count_low && !WR_STROBE.count_high)
        |=> ({COUNT_HIGH, COUNT_LOW} == $past({RELOAD_HIGH, RELOAD_LOW})) && ctrl_q.high_overflow_flag)
        else $error("16-bit wrap did not reload or flag");

    high_flag_sticky_a: assert property (                             // see R15
        (ctrl_q.high_overflow_flag && !WR_STROBE.control) |=> ctrl_q.high_overflow_flag)
        else $error("high flag cleared by hardware");

    low_flag_set_a: assert property (                                 // see R13
        lo_wrap |=> ctrl_q.low_overflow_flag && TIMER_CONTROL.low_overflow_flag)
        else $error("low wrap did not set low flag");

    irq_high_a: assert property (                                     // see R8
        (ctrl_q.high_overflow_flag && TIMER_IRQ_ENABLE) |=> TIMER_IRQ)
        else $error("overflow flag gave no interrupt");

    irq_low_gate_a: assert property (                                 // see R9
        (!ctrl_q.high_overflow_flag && !ctrl_q.low_byte_irq_enable) |=> !TIMER_IRQ)
        else $error("low flag interrupted while disabled");

    irq_enable_gate_a: assert property (                              // see R8
        !TIMER_IRQ_ENABLE |=> !TIMER_IRQ)
        else $error("interrupt raised while disabled");

    high_core_step_a: assert property (                               // see R12
        (split && run && CLOCK_SELECT.high_byte_clock_select && !WR_STROBE.count_high
         && COUNT_HIGH != `BYTE_ALL_ONES) |=> (COUNT_HIGH == $past(COUNT_HIGH) + 8'h01))
        else $error("high byte missed a core clock step");

    split_run_gate_a: assert property (                               // see R11
        (split && !run && !WR_STROBE.count_high) |=> $stable(COUNT_HIGH))
        else $error("high byte ran without run control");

    reserved_hold_a: assert property (                                // see R21
        (!CLOCK_SELECT.low_byte_clock_select
         && ctrl_q.ext_clock_field == `XCLK_RESERVED && !WR_STROBE.count_low) |=> $stable(COUNT_LOW))
        else $error("low byte counted on reserved clock");

    capture_copy_a: assert property (                                 // see R16
        cap_ev |=> ({RELOAD_HIGH, RELOAD_LOW} == $past({COUNT_HIGH, COUNT_LOW}))
                   && ctrl_q.high_overflow_flag)
        else $error("capture did not copy count");

    wake_pulse_a: assert property (                                   // see R4
        (state_q == ST_SUSPENDED && hi_wrap) |=> WAKE_REQ ##1 !WAKE_REQ)
        else $error("suspend overflow gave no wake pulse");

    busy_start_a: assert property (                                   // see R5
        (state_q == ST_SUSPENDED && !hi_wrap && !SUSPEND) |=> SYNC_BUSY_FLAG)
        else $error("busy flag missing after other wake");

    div12_gap_a: assert property (                                    // see R2
        tick12_q |=> !tick12_q [*8])
        else $error("core divide by twelve too fast");

endmodule // osc_capture_timer

`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Self-checking bench for the auto-reload capture timer
module tb_top;
    import osc_timer_pkg::*;

    logic           clk;
    logic           rstn;
    write_strobe_t  wr_strobe;
    logic [7:0]     wr_data;
    clock_select_t  clock_select;
    logic           irq_enable;
    logic           slow_div_one;
    logic           suspend;
    logic           ext_osc;
    logic           slow_osc;
    timer_control_t tctl;
    logic [7:0]     cnt_lo;
    logic [7:0]     cnt_hi;
    logic [7:0]     rld_lo;
    logic [7:0]     rld_hi;
    logic           timer_irq;
    logic           wake_req;
    logic           sync_busy;
    int             err_count;
    int             cmp_count;
    int             n;

    osc_capture_timer osc_capture_timer_i (
        .CLK              (clk),
        .RSTN             (rstn),
        .WR_STROBE        (wr_strobe),
        .WR_DATA          (wr_data),
        .CLOCK_SELECT     (clock_select),
        .TIMER_IRQ_ENABLE (irq_enable),
        .SLOW_DIV_IS_ONE  (slow_div_one),
        .SUSPEND          (suspend),
        .EXT_OSC_CLK      (ext_osc),
        .SLOW_OSC_CLK     (slow_osc),
        .TIMER_CONTROL    (tctl),
        .COUNT_LOW        (cnt_lo),
        .COUNT_HIGH       (cnt_hi),
        .RELOAD_LOW       (rld_lo),
        .RELOAD_HIGH      (rld_hi),
        .TIMER_IRQ        (timer_irq),
        .WAKE_REQ         (wake_req),
        .SYNC_BUSY_FLAG   (sync_busy)
    );

    // ==========================================================
    // Clock, 10 ns period
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Helpers
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, seen, exp);
        end
    endtask

    task automatic chk1(input logic seen, input logic exp, input string msg);
        chk({15'h0000, seen}, {15'h0000, exp}, msg);
    endtask

    // Strobe index: 4 control, 3 reload low, 2 reload high, 1 count low, 0 count high
    task automatic wr(input int k, input logic [7:0] d);
        @(negedge clk);
        wr_strobe = write_strobe_t'(5'h01 << k);
        wr_data   = d;
        @(negedge clk);
        wr_strobe = '0;
    endtask

    // Bounded wait on one control bit; the caller compares afterwards
    task automatic wflag(input int b);
        n = 0;
        while (tctl[b] !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    // Slow square pulses on one oscillator pin, wide enough for the synchroniser
    task automatic pulses(input logic use_slow, input int k);
        repeat (k)
        begin
            if (use_slow) slow_osc = 1'b1; else ext_osc = 1'b1;
            cyc(3);
            if (use_slow) slow_osc = 1'b0; else ext_osc = 1'b0;
            cyc(3);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Watchdog, far beyond the several hundred cycles the tests need
    initial
    begin
        #200000;
        err_count++;
        wrap_up();
    end

    // ==========================================================
    // Test sequence; control byte {H,L,LEN,CEN,SPLIT,RUN,XCLK}
    initial
    begin
        err_count = 0;
        cmp_count = 0;
        rstn = 1'b0; wr_strobe = '0; wr_data = 8'h00; clock_select = '0;
        irq_enable = 1'b1; slow_div_one = 1'b1; suspend = 1'b0; ext_osc = 1'b0; slow_osc = 1'b0;
        cyc(10);
        rstn = 1'b1;
        cyc(1);
        chk({tctl, cnt_lo}, 16'h0000, "reset control");
        chk({rld_hi, cnt_hi}, 16'h0000, "reset bytes");
        $display("test reset done");

        // 16-bit wrap from FFFF on core/12 reloads and sets high flag
        wr(3, 8'h34); wr(2, 8'h12); wr(1, 8'hFE); wr(0, 8'hFF);
        wr(4, 8'h04);
        wflag(7);
        chk1(tctl.high_overflow_flag, 1'b1, "high flag");
        chk({cnt_hi, cnt_lo}, 16'h1234, "reloaded count");
        cyc(2);
        chk1(timer_irq, 1'b1, "overflow irq");
        cyc(30);
        chk1(tctl.high_overflow_flag, 1'b1, "flag held");
        irq_enable = 1'b0;
        cyc(2);
        chk1(timer_irq, 1'b0, "irq masked");
        irq_enable = 1'b1;
        wr(4, 8'h04);
        cyc(3);
        chk1(timer_irq, 1'b0, "irq after clear");
        $display("test wrap16 done");

        // Low-byte wrap in 16-bit mode, with and without low interrupt enable
        for (int i = 0; i < 2; i++)
        begin
            wr(4, 8'h00); wr(1, 8'hFE); wr(0, 8'h00);
            wr(4, i ? 8'h24 : 8'h04);
            wflag(6);
            chk({tctl.high_overflow_flag, cnt_hi}, 16'h0001, "carry");
            cyc(2);
            chk1(timer_irq, i[0], "low irq");
        end
        $display("test lowbyte done");

        // Split: low byte free-running on core, high byte on core/12 gated by run
        clock_select = 2'b01;
        wr(4, 8'h08); wr(3, 8'hF0); wr(2, 8'h55); wr(0, 8'hFF); wr(1, 8'hF0);
        wflag(6);
        chk(cnt_lo, 16'h00F0, "low reload");
        chk(cnt_hi, 16'h00FF, "high held");
        chk1(tctl.high_overflow_flag, 1'b0, "no high flag");
        cyc(2);
        chk1(timer_irq, 1'b0, "no low irq");
        wr(4, 8'h0C);
        wflag(7);
        chk(cnt_hi, 16'h0055, "high reload");
        cyc(2);
        chk1(timer_irq, 1'b1, "high irq");
        wr(4, 8'h28);
        wflag(6);
        cyc(2);
        chk1(timer_irq, 1'b1, "low split irq");
        // High byte on the core clock must wrap within 20 cycles
        clock_select = 2'b10;
        wr(4, 8'h0C); wr(0, 8'hF0);
        wflag(7);
        chk(cnt_hi, 16'h0055, "high core reload");
        chk1(n < 20, 1'b1, "high on core clock");
        $display("test split done");

        // Reserved field gives no clock
        clock_select = 2'b00;
        wr(4, 8'h00); wr(1, 8'h00); wr(0, 8'h00); wr(4, 8'h06);
        cyc(50);
        chk({cnt_hi, cnt_lo}, 16'h0000, "reserved still");
        // External /8: sixteen edges give two counts
        wr(4, 8'h05);
        pulses(1'b0, 16);
        cyc(8);
        chk({cnt_hi, cnt_lo}, 16'h0002, "ext div8");
        // Slow /8 blocked unless its divider is one
        wr(4, 8'h00); wr(1, 8'h00); wr(0, 8'h00);
        slow_div_one = 1'b0;
        wr(4, 8'h07);
        pulses(1'b1, 16);
        cyc(8);
        chk({cnt_hi, cnt_lo}, 16'h0000, "slow blocked");
        slow_div_one = 1'b1;
        pulses(1'b1, 16);
        cyc(8);
        chk({cnt_hi, cnt_lo}, 16'h0002, "slow div8");
        $display("test sources done");

        // Capture on slow falling edge while counting on core clock
        clock_select = 2'b01;
        wr(4, 8'h00); wr(1, 8'h00); wr(0, 8'h00); wr(3, 8'h00); wr(2, 8'h00);
        wr(4, 8'h14);
        cyc(10);
        slow_osc = 1'b1;
        cyc(5);
        chk1(tctl.high_overflow_flag, 1'b0, "no capture on rise");
        slow_osc = 1'b0;
        wflag(7);
        chk1(tctl.high_overflow_flag, 1'b1, "capture flag");
        chk({cnt_hi, cnt_lo} - {rld_hi, rld_lo}, 16'h0001, "captured count");
        $display("test capture done");

        // Overflow during suspend wakes the device
        wr(4, 8'h00); wr(1, 8'hF0); wr(0, 8'hFF); wr(4, 8'h04);
        suspend = 1'b1;
        n = 0;
        while (wake_req !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        chk1(wake_req, 1'b1, "wake pulse");
        suspend = 1'b0;
        cyc(1);
        chk1(sync_busy, 1'b0, "no busy on timer wake");
        // Other wake source: busy for three core/12 ticks
        clock_select = 2'b00;
        wr(4, 8'h04); wr(1, 8'h00); wr(0, 8'h00);
        suspend = 1'b1;
        cyc(5);
        suspend = 1'b0;
        cyc(1);
        chk1(sync_busy, 1'b1, "busy set");
        cyc(12);
        chk1(sync_busy, 1'b1, "busy held");
        cyc(30);
        chk1(sync_busy, 1'b0, "busy cleared");
        $display("test suspend done");
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
